// ---- design/pao_consts.svh ----
// Register map, field positions and reset values of the port A override block.
// Included by the single design module and by the testbench.
`ifndef PAO_CONSTS_SVH
`define PAO_CONSTS_SVH

`define PAO_ADR_DIR 8'h00
`define PAO_ADR_OUT 8'h04
`define PAO_ADR_PUE 8'h08
`define PAO_ADR_IN 8'h0c
`define PAO_ADR_CFG 8'h10
`define PAO_ADR_STAT 8'h14

`define PAO_CFG_REMAP 0
`define PAO_CFG_EXTCLK 1
`define PAO_STAT_RSTDIS 0
`define PAO_STAT_SLEEP 1

`define PAO_RST_PORT 8'h00
`define PAO_RST_CFG 2'h0

`define PAO_PIN_CLK 0
`define PAO_PIN_DATA 1
`define PAO_PIN_RST 2
`define PAO_PIN_CMPA 3
`define PAO_PIN_CAP 4
`define PAO_PIN_CMPB_ALT 5

`endif

// ---- design/pao_pkg.sv ----
// Types of the port A override block.
// Assumes the constants header sits beside it.
package pao_pkg;
    typedef struct packed {
        logic pullup_override_enable;
        logic pullup_override_value;
        logic direction_override_enable;
        logic direction_override_value;
        logic pin_value_override_enable;
        logic pin_value_override_value;
        logic output_toggle_override_enable;
        logic input_gate_override_enable;
        logic input_gate_override_value;
    } pao_ovr_t;

    typedef struct packed {
        logic [7:0] direction_bit;
        logic [7:0] output_value_bit;
        logic [7:0] pullup_enable_bit;
        logic [7:0] sync_meta;
        logic [7:0] pin_input_bit;
        logic [1:0] cfg;
        logic reset_pin_disabled;
        logic ack;
        logic [31:0] rdata;
    } pao_state_t;
endpackage

// ---- design/pao_port_a.sv ----
// Port A pin control with per-pin alternate function overrides and a Wishbone slave.
// Assumes pad inputs asynchronous to clk_i, peripherals driving per-pin overrides.
`timescale 1ns/10ps
`include "pao_consts.svh"

// What this block does
// - Without pull-up override, pull-up follows the pull-up enable register bit.
// - With pull-up override, pull-up follows the override value only.
// - Without direction override, driver enable follows the direction bit.
// - With direction override, driver enable follows the direction override value.
// - Driven pin with value override takes the override value.
// - Driven pin without value override takes the output register bit.
// - Toggle override inverts the pin's output register bit.
// - Without input override, digital input is clamped during sleep.
// - With input override, the override value gates the digital input.
// - Raw input goes out before the synchronizer; users synchronise it.
// - Analog signal taken straight from the pad, bypassing digital gating.
// - Register strobes shared per port, overrides separate per pin.
// - Pin 0 carries timer count, external clock, programming clock, change 0.
// - Compare B on pin 1 by default, pin 5 when remapped; pin 1 programming data.
// - Compare A on pin 3 and capture on pin 4 when remapped.
// - Each pin n is pin change source n; pin 2 is the reset input.
// - Writing one to an input register bit inverts the output bit.
// - External clock selected flag drives pin 0 overrides when set.
// - Reset pin disabled is one when its configuration bit reads zero.
module pao_port_a (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Per-pin overrides from peripherals
    input wire pao_pkg::pao_ovr_t [7:0] ovr_i,
    // Timer compare outputs
    input wire logic timer_compare_a_out_i,
    input wire logic timer_compare_a_en_i,
    input wire logic timer_compare_b_out_i,
    input wire logic timer_compare_b_en_i,
    // System state
    input wire logic sleep_i,
    input wire logic reset_fuse_i,
    // Pads
    input wire logic [7:0] pad_i,
    output logic [7:0] pad_o,
    output logic [7:0] pad_oe_o,
    output logic [7:0] pad_pullup_o,
    // Inputs to peripherals
    output logic [7:0] raw_pin_input_o,
    output logic [7:0] analog_pad_signal_o,
    output logic [7:0] pin_change_source_o,
    output logic timer_external_count_in_o,
    output logic external_main_clock_in_o,
    output logic programming_clock_o,
    output logic programming_data_o,
    output logic timer_capture_in_o,
    output logic reset_pin_in_o,
    output logic external_clock_selected_o,
    output logic reset_pin_disabled_o
);
    import pao_pkg::*;

    pao_state_t s_q;
    pao_state_t s_d;
    pao_ovr_t [7:0] eff;
    logic [7:0] toggle;
    logic remap;
    logic ext_clk;
    logic req;
    logic wr;

    assign remap = s_q.cfg[`PAO_CFG_REMAP];
    assign ext_clk = s_q.cfg[`PAO_CFG_EXTCLK];
    assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign wr = req && wb_we_i && wb_sel_i[0];

    // Merge module overrides with the fixed port A functions
    always_comb begin
        eff = ovr_i;
        // External clock owns pin 0
        if (ext_clk) begin
            eff[`PAO_PIN_CLK].pullup_override_enable = 1'b1;
            eff[`PAO_PIN_CLK].pullup_override_value = 1'b0;
            eff[`PAO_PIN_CLK].direction_override_enable = 1'b1;
            eff[`PAO_PIN_CLK].direction_override_value = 1'b0;
            eff[`PAO_PIN_CLK].pin_value_override_enable = 1'b1;
            eff[`PAO_PIN_CLK].pin_value_override_value = 1'b0;
        end
        // Reset input keeps its pull-up, driver off
        if (!s_q.reset_pin_disabled) begin
            eff[`PAO_PIN_RST].pullup_override_enable = 1'b1;
            eff[`PAO_PIN_RST].pullup_override_value = 1'b1;
            eff[`PAO_PIN_RST].direction_override_enable = 1'b1;
            eff[`PAO_PIN_RST].direction_override_value = 1'b0;
        end
        // Compare B default or alternative pin
        if (timer_compare_b_en_i && !remap) begin
            eff[`PAO_PIN_DATA].pin_value_override_enable = 1'b1;
            eff[`PAO_PIN_DATA].pin_value_override_value = timer_compare_b_out_i;
        end
        if (timer_compare_b_en_i && remap) begin
            eff[`PAO_PIN_CMPB_ALT].pin_value_override_enable = 1'b1;
            eff[`PAO_PIN_CMPB_ALT].pin_value_override_value = timer_compare_b_out_i;
        end
        if (timer_compare_a_en_i && remap) begin
            eff[`PAO_PIN_CMPA].pin_value_override_enable = 1'b1;
            eff[`PAO_PIN_CMPA].pin_value_override_value = timer_compare_a_out_i;
        end
    end

    // Per-pin control, combinational
    genvar n;
    generate
        for (n = 0; n < 8; n++) begin : g_pin
            logic drv;
            logic gate;
            assign drv = eff[n].direction_override_enable ?
                eff[n].direction_override_value : s_q.direction_bit[n];
            assign gate = eff[n].input_gate_override_enable ?
                eff[n].input_gate_override_value : !sleep_i;
            assign pad_oe_o[n] = drv;
            assign pad_o[n] = eff[n].pin_value_override_enable ?
                eff[n].pin_value_override_value : s_q.output_value_bit[n];
            assign pad_pullup_o[n] = eff[n].pullup_override_enable ?
                eff[n].pullup_override_value : s_q.pullup_enable_bit[n];
            assign raw_pin_input_o[n] = pad_i[n] && gate;
            assign toggle[n] = eff[n].output_toggle_override_enable;
        end
    endgenerate

    assign analog_pad_signal_o = pad_i;
    assign pin_change_source_o = raw_pin_input_o;
    assign timer_external_count_in_o = raw_pin_input_o[`PAO_PIN_CLK];
    assign external_main_clock_in_o = raw_pin_input_o[`PAO_PIN_CLK];
    assign programming_clock_o = raw_pin_input_o[`PAO_PIN_CLK];
    assign programming_data_o = raw_pin_input_o[`PAO_PIN_DATA];
    assign timer_capture_in_o = remap && raw_pin_input_o[`PAO_PIN_CAP];
    assign reset_pin_in_o = raw_pin_input_o[`PAO_PIN_RST];
    assign external_clock_selected_o = ext_clk;
    assign reset_pin_disabled_o = s_q.reset_pin_disabled;
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.sync_meta = pad_i;
        s_d.pin_input_bit = s_q.sync_meta;
        s_d.reset_pin_disabled = !reset_fuse_i;
        s_d.ack = req;
        s_d.rdata = 32'h0000_0000;
        if (wr) begin
            unique case (wb_adr_i)
                `PAO_ADR_DIR: s_d.direction_bit = wb_dat_i[7:0];
                `PAO_ADR_OUT: s_d.output_value_bit = wb_dat_i[7:0];
                `PAO_ADR_PUE: s_d.pullup_enable_bit = wb_dat_i[7:0];
                `PAO_ADR_IN: s_d.output_value_bit = s_q.output_value_bit ^ wb_dat_i[7:0];
                `PAO_ADR_CFG: s_d.cfg = wb_dat_i[1:0];
                default: s_d.cfg = s_q.cfg;
            endcase
        end
        s_d.output_value_bit = s_d.output_value_bit ^ toggle;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                `PAO_ADR_DIR: s_d.rdata[7:0] = s_q.direction_bit;
                `PAO_ADR_OUT: s_d.rdata[7:0] = s_q.output_value_bit;
                `PAO_ADR_PUE: s_d.rdata[7:0] = s_q.pullup_enable_bit;
                `PAO_ADR_IN: s_d.rdata[7:0] = s_q.pin_input_bit;
                `PAO_ADR_CFG: s_d.rdata[1:0] = s_q.cfg;
                `PAO_ADR_STAT: s_d.rdata[1:0] = {sleep_i, s_q.reset_pin_disabled};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.direction_bit <= `PAO_RST_PORT;
            s_q.output_value_bit <= `PAO_RST_PORT;
            s_q.pullup_enable_bit <= `PAO_RST_PORT;
            s_q.cfg <= `PAO_RST_CFG;
        end else begin
            s_q <= s_d;
        end
    end

    // Checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_pue_write;
        wb_ack_o && $past(wb_we_i && wb_sel_i[0] && wb_adr_i == `PAO_ADR_PUE)
            && !ovr_i[7].pullup_override_enable
            |-> pad_pullup_o[7] == $past(wb_dat_i[7]);
    endproperty
    a_pue_write: assert property (p_pue_write) else $error("pull-up not from register");

    property p_pu_ovr;
        ovr_i[6].pullup_override_enable |-> pad_pullup_o[6] == ovr_i[6].pullup_override_value;
    endproperty
    a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up override ignored");

    property p_dir_write;
        wb_ack_o && $past(wb_we_i && wb_sel_i[0] && wb_adr_i == `PAO_ADR_DIR)
            && !ovr_i[7].direction_override_enable
            |-> pad_oe_o[7] == $past(wb_dat_i[7]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("driver not from register");

    property p_dir_ovr;
        ovr_i[6].direction_override_enable |-> pad_oe_o[6] == ovr_i[6].direction_override_value;
    endproperty
    a_dir_ovr: assert property (p_dir_ovr) else $error("direction override ignored");

    property p_toggle;
        ovr_i[6].output_toggle_override_enable && !wr
            |=> s_q.output_value_bit[6] != $past(s_q.output_value_bit[6]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle override lost");

    property p_in_write;
        wr && wb_adr_i == `PAO_ADR_IN && wb_dat_i[7] && !ovr_i[7].output_toggle_override_enable
            |=> s_q.output_value_bit[7] != $past(s_q.output_value_bit[7]);
    endproperty
    a_in_write: assert property (p_in_write) else $error("input write did not toggle");

    property p_sleep;
        sleep_i && !ovr_i[7].input_gate_override_enable |-> raw_pin_input_o[7] == 1'b0;
    endproperty
    a_sleep: assert property (p_sleep) else $error("input not clamped in sleep");

    property p_gate_ovr;
        ovr_i[7].input_gate_override_enable && ovr_i[7].input_gate_override_value
            |-> raw_pin_input_o[7] == pad_i[7];
    endproperty
    a_gate_ovr: assert property (p_gate_ovr) else $error("input override ignored");

    property p_cmpb_alt;
        remap && timer_compare_b_en_i && !ovr_i[5].pin_value_override_enable
            |-> pad_o[5] == timer_compare_b_out_i;
    endproperty
    a_cmpb_alt: assert property (p_cmpb_alt) else $error("compare B not on pin 5");

    property p_rstdis;
        ##1 reset_pin_disabled_o == !$past(reset_fuse_i);
    endproperty
    a_rstdis: assert property (p_rstdis) else $error("reset disable wrong");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

    property p_value_ovr;
        ovr_i[7].pin_value_override_enable
            |-> pad_o[7] == ovr_i[7].pin_value_override_value;
    endproperty
    a_value_ovr: assert property (p_value_ovr) else $error("value override ignored");

    property p_value_reg;
        wb_ack_o && $past(wr && wb_adr_i == `PAO_ADR_OUT) && !$past(toggle[7])
            && !ovr_i[7].pin_value_override_enable |-> pad_o[7] == $past(wb_dat_i[7]);
    endproperty
    a_value_reg: assert property (p_value_reg) else $error("value not from register");

    property p_raw_path;
        !sleep_i && !ovr_i[6].input_gate_override_enable
            |-> raw_pin_input_o[6] == pad_i[6];
    endproperty
    a_raw_path: assert property (p_raw_path) else $error("raw input not from pad");

    property p_analog;
        analog_pad_signal_o == pad_i;
    endproperty
    a_analog: assert property (p_analog) else $error("analog path gated");

    property p_pin0_fan;
        timer_external_count_in_o == raw_pin_input_o[0]
            && external_main_clock_in_o == raw_pin_input_o[0]
            && programming_clock_o == raw_pin_input_o[0];
    endproperty
    a_pin0_fan: assert property (p_pin0_fan) else $error("pin 0 functions not routed");

    property p_cmpb_dflt;
        !remap && timer_compare_b_en_i
            |-> pad_o[1] == timer_compare_b_out_i
            && programming_data_o == raw_pin_input_o[1];
    endproperty
    a_cmpb_dflt: assert property (p_cmpb_dflt) else $error("compare B not on pin 1");

    property p_cmpa_alt;
        remap && timer_compare_a_en_i
            |-> pad_o[3] == timer_compare_a_out_i;
    endproperty
    a_cmpa_alt: assert property (p_cmpa_alt) else $error("compare A not on pin 3");

    property p_capture;
        remap |-> timer_capture_in_o == raw_pin_input_o[4];
    endproperty
    a_capture: assert property (p_capture) else $error("capture not from pin 4");

    property p_pcint;
        pin_change_source_o == raw_pin_input_o
            && reset_pin_in_o == raw_pin_input_o[2];
    endproperty
    a_pcint: assert property (p_pcint) else $error("pin change sources wrong");

    property p_rst_pin;
        !reset_pin_disabled_o |-> pad_pullup_o[2] && !pad_oe_o[2];
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin not held as input");

    property p_extclk;
        external_clock_selected_o
            |-> !pad_pullup_o[0] && !pad_oe_o[0] && !pad_o[0];
    endproperty
    a_extclk: assert property (p_extclk) else $error("external clock pin not released");

    property p_same_cycle;
        $rose(ovr_i[6].direction_override_enable)
            |-> pad_oe_o[6] == ovr_i[6].direction_override_value;
    endproperty
    a_same_cycle: assert property (p_same_cycle) else $error("override late");

    property p_pu_hold;
        !wb_ack_o && !ovr_i[7].pullup_override_enable
            && !$past(ovr_i[7].pullup_override_enable) |-> $stable(pad_pullup_o[7]);
    endproperty
    a_pu_hold: assert property (p_pu_hold) else $error("pull-up moved without write");

    property p_dir_hold;
        !wb_ack_o && !ovr_i[7].direction_override_enable
            && !$past(ovr_i[7].direction_override_enable) |-> $stable(pad_oe_o[7]);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("driver moved without write");

    c_toggle: cover property (ovr_i[6].output_toggle_override_enable);
    c_sleep_ovr: cover property (sleep_i && ovr_i[7].input_gate_override_enable);
    c_remap: cover property (remap && timer_compare_a_en_i);
    c_extclk: cover property (ext_clk ##1 wb_ack_o);
endmodule

// ---- testbench/pao_periph_model.sv ----
// Peripheral side model: per-pin override bundles and an input synchroniser.
// Assumes the bench loads one pin bundle per load pulse.
`timescale 1ns/10ps
module pao_periph_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Load request
    input wire logic load_i,
    input wire logic [2:0] pin_i,
    input wire pao_pkg::pao_ovr_t set_i,
    // Pin side
    input wire logic [7:0] raw_i,
    output pao_pkg::pao_ovr_t [7:0] ovr_o,
    output logic [7:0] synced_o
);
    import pao_pkg::*;
    logic [7:0] meta_q;
    always_ff @(posedge clk_i) begin
        meta_q <= raw_i;
        synced_o <= meta_q;
        if (rst_i) begin
            ovr_o <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                ovr_o[i].output_toggle_override_enable <= 1'b0;
            end
            if (load_i) begin
                ovr_o[pin_i] <= set_i;
            end
        end
    end
endmodule

// ---- testbench/test_pao_port_a.sv ----
// Bench for the port A override block: Wishbone tasks and override sequences.
// Assumes the peripheral model file is compiled first.
`timescale 1ns/10ps
`include "pao_consts.svh"
module test_pao_port_a;
    import pao_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack, load, ca, cae, cb, cbe, sleep, fuse;
    logic [7:0] adr, pad, po, poe, pu, raw, ana, pcs, synced;
    logic [2:0] pin;
    logic [31:0] wdat, rdat, r;
    logic [4:0] fixd;
    logic [2:0] misc;
    pao_ovr_t set, s;
    pao_ovr_t [7:0] ovr;
    int err_count = 0;
    int samples_checked = 0;
    int cyc_n = 0;
    pao_port_a i_pao_port_a (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ovr_i(ovr), .timer_compare_a_out_i(ca), .timer_compare_a_en_i(cae),
        .timer_compare_b_out_i(cb), .timer_compare_b_en_i(cbe), .sleep_i(sleep),
        .reset_fuse_i(fuse), .pad_i(pad), .pad_o(po), .pad_oe_o(poe), .pad_pullup_o(pu),
        .raw_pin_input_o(raw), .analog_pad_signal_o(ana), .pin_change_source_o(pcs),
        .timer_external_count_in_o(fixd[4]), .external_main_clock_in_o(fixd[3]),
        .programming_clock_o(fixd[2]), .programming_data_o(fixd[1]),
        .timer_capture_in_o(misc[0]), .reset_pin_in_o(fixd[0]),
        .external_clock_selected_o(misc[1]), .reset_pin_disabled_o(misc[2]));
    pao_periph_model i_pao_periph_model (.clk_i(clk_i), .rst_i(rst_i), .load_i(load),
        .pin_i(pin), .set_i(set), .raw_i(raw), .ovr_o(ovr), .synced_o(synced));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 8'h00);
        chk(r, exp);
    endtask
    task automatic ovr_set(input logic [2:0] p, input pao_ovr_t v);
        @(posedge clk_i);
        load <= 1'b1;
        pin <= p;
        set <= v;
        @(posedge clk_i);
        load <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        {rst_i, fuse} = 2'b11;
        {cyc, stb, we, load, ca, cae, cb, cbe, sleep} = '0;
        {adr, pad, wdat, pin, set} = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rdc(8'(i * 4), 32'h0);
        end
        chk(32'({poe, pu}), 32'h0004);
        $display("reset test done");
        wb(1'b1, `PAO_ADR_PUE, 8'h40);
        wb(1'b1, `PAO_ADR_DIR, 8'hc0);
        wb(1'b1, `PAO_ADR_OUT, 8'h80);
        chk(32'({pu, poe, po[7:6]}), 32'({8'h44, 8'hc0, 2'b10}));
        s = '0;
        s.pullup_override_enable = 1'b1;
        s.direction_override_enable = 1'b1;
        ovr_set(3'd6, s);
        s = '1;
        s.output_toggle_override_enable = 1'b0;
        s.input_gate_override_enable = 1'b0;
        ovr_set(3'd5, s);
        s = '0;
        s.pin_value_override_enable = 1'b1;
        ovr_set(3'd7, s);
        chk(32'({pu, poe, po[7], po[5]}), 32'({8'h24, 8'ha0, 2'b01}));
        for (int p = 5; p < 8; p++) begin
            ovr_set(3'(p), '0);
        end
        $display("override test done");
        wb(1'b1, `PAO_ADR_IN, 8'h81);
        rdc(`PAO_ADR_OUT, 32'h01);
        s = '0;
        s.output_toggle_override_enable = 1'b1;
        ovr_set(3'd6, s);
        rdc(`PAO_ADR_OUT, 32'h41);
        $display("toggle test done");
        @(posedge clk_i);
        pad <= 8'hff;
        sleep <= 1'b1;
        #1;
        chk(32'({raw[7:6], ana}), 32'({2'b00, 8'hff}));
        s = '0;
        s.input_gate_override_enable = 1'b1;
        s.input_gate_override_value = 1'b1;
        ovr_set(3'd7, s);
        chk(32'(raw[7:6]), 32'h2);
        @(posedge clk_i);
        pad <= 8'hb5;
        sleep <= 1'b0;
        #1;
        chk(32'({raw, pcs, fixd, misc[0]}), 32'({8'hb5, 8'hb5, 5'b11101, 1'b0}));
        repeat (2) @(posedge clk_i);
        #1;
        chk(32'(synced), 32'hb5);
        rdc(`PAO_ADR_IN, 32'hb5);
        $display("input test done");
        @(posedge clk_i);
        {ca, cae, cb, cbe} <= 4'hf;
        wb(1'b1, `PAO_ADR_DIR, 8'h2a);
        chk(32'({po[5], po[3], po[1]}), 32'h1);
        wb(1'b1, `PAO_ADR_CFG, 8'h01);
        chk(32'({po[5], po[3], po[1], misc[0]}), 32'hd);
        $display("compare test done");
        wb(1'b1, `PAO_ADR_PUE, 8'h01);
        wb(1'b1, `PAO_ADR_DIR, 8'h01);
        wb(1'b1, `PAO_ADR_CFG, 8'h02);
        chk(32'({misc[1], pu[0], poe[0]}), 32'h4);
        @(posedge clk_i);
        fuse <= 1'b0;
        sleep <= 1'b1;
        rdc(`PAO_ADR_STAT, 32'h03);
        chk(32'({misc[2], pu[2]}), 32'h2);
        wb(1'b1, `PAO_ADR_CFG, 8'h00);
        wb(1'b1, `PAO_ADR_PUE, 8'h00);
        wb(1'b1, `PAO_ADR_DIR, 8'h00);
        chk(32'({pu[0], poe[0], ana[0]}), 32'h1);
        $display("fixed function test done");
        conclude();
    end
endmodule
